// *** logic/rxeqd_debug_ports.sv ***
// Purpose: Receive lane equalizer, clock recovery and eye-scan debug
// Assumes: pclk is the lane recovered clock; raw flags are asynchronous
// Notes:   Control and status over APB, zero-wait access phase
// Notes on behaviour
// RQ1: High-frequency hold freezes boost, else adapts
// RQ2: Low-frequency hold freezes boost, else adapts
// RQ3: Select zero feedback path, one linear path
// RQ4: Clock recovery hold freezes the recovery loop
// RQ5: Adaptation reset pulsed; process starts on release
// RQ6: Variant zero: gain on monitor bits 4:0
// RQ7: Variant one: four-bit gain on bits 4:1
// RQ8: Select 01 gain, 10 threshold, 11 offset
// RQ9: Eye-scan reset pulsed; process starts on release
// RQ10: One-cycle error pulse while armed or counting
// RQ11: Trigger input causes an eye-scan trigger event
// RQ12: Aligned flag high only while byte aligned
// RQ13: Comma flag precedes parallel comma by cycles
// RQ14: Reserved recovery override held at zero; the code stores the written bit, which reads back but drives nothing
`timescale 1ns/1ps
`default_nettype none
`include "rxeqd_consts.svh"
module rxeqd_debug_ports
  import rxeqd_pkg::*;
#(
  parameter int         VARIANT   = 0,               // 0 five-bit gain, 1 four-bit
  parameter logic [7:0] COUNT_LEN = `RXEQD_COUNT_LEN // Eye-scan count window
)(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Analog front end
  input  wire rxeqd_loops_t loop_tgt,
  input  wire logic [3:0]   phase_err,
  input  wire logic         comma_raw,
  input  wire logic         err_raw,
  input  wire logic         misalign_raw,
  // Lane outputs
  output logic              eq_path_lpm,
  output rxeqd_loops_t      loop_val,
  output logic [7:0]        cdr_phase,
  output logic [6:0]        monitor_out,
  output logic              es_error,
  output logic              byte_aligned,
  output logic              comma_det,
  output logic              comma_at_par,
  output logic              irq
);
  // ==========================================================
  // State
  rxeqd_state_t r;        // Registered state
  rxeqd_state_t r_nxt;    // Next state
  logic         wr_en;    // Write taken this edge
  logic         cm_ev;    // Filtered comma rising edge
  logic         er_ev;    // Filtered error rising edge
  logic         ma_ev;    // Filtered misalign rising edge
  logic [2:0]   ev;       // Interrupt events
  logic [2:0]   clr;      // Interrupt clear mask

  // One step of a loop towards its target
  function automatic logic [6:0] step_loop(input logic [6:0] cur, input logic [6:0] tgt);
    if (cur < tgt)
    begin
      step_loop = cur + 7'h01;
    end
    else if (cur > tgt)
    begin
      step_loop = cur - 7'h01;
    end
    else
    begin
      step_loop = cur;
    end
  endfunction : step_loop

  // ==========================================================
  // Next state
  always_comb
  begin
    r_nxt = r;
    wr_en = psel && penable && pwrite;
    clr   = '0;
    // Three-flop synchronisers; change counts when 2nd and 3rd agree
    r_nxt.s_cm = {r.s_cm[1:0], comma_raw};
    r_nxt.s_er = {r.s_er[1:0], err_raw};
    r_nxt.s_ma = {r.s_ma[1:0], misalign_raw};
    if (r.s_cm[1] == r.s_cm[2])
    begin
      r_nxt.f_cm = r.s_cm[2];
    end
    if (r.s_er[1] == r.s_er[2])
    begin
      r_nxt.f_er = r.s_er[2];
    end
    if (r.s_ma[1] == r.s_ma[2])
    begin
      r_nxt.f_ma = r.s_ma[2];
    end
    cm_ev = r_nxt.f_cm && !r.f_cm;
    er_ev = r_nxt.f_er && !r.f_er;
    ma_ev = r_nxt.f_ma && !r.f_ma;

    // Register writes; trigger lasts one cycle only
    r_nxt.ctrl.es_trig = 1'h0;
    if (wr_en)
    begin
      case (paddr)
        `RXEQD_CTRL_OFS: r_nxt.ctrl = pwdata[`RXEQD_CTRL_W-1:0];
        `RXEQD_IEN_OFS:  r_nxt.ien  = pwdata[`RXEQD_IRQ_W-1:0];
        `RXEQD_ICLR_OFS: clr        = pwdata[`RXEQD_IRQ_W-1:0];
        default:         r_nxt.ien  = r.ien;
      endcase
    end
    r_nxt.adapt_rst_q = r.ctrl.adapt_rst;
    r_nxt.es_rst_q    = r.ctrl.es_rst;

    // Linear path adapts the boosts, feedback path the other loops
    if (r.ctrl.adapt_rst)
    begin
      // Loops wait while the reset is held; release restarts them
      r_nxt.loops = r.loops;
    end
    else if (r.adapt_rst_q)
    begin
      r_nxt.loops = {`RXEQD_BOOST_INIT, `RXEQD_BOOST_INIT, `RXEQD_BOOST_INIT,
                     `RXEQD_BOOST_INIT, `RXEQD_GAIN_INIT}; // [RQ5]
    end
    else if (r.ctrl.lpm_sel) // [RQ3]
    begin
      r_nxt.loops.hf = step_loop(r.loops.hf, loop_tgt.hf);
      r_nxt.loops.lf = step_loop(r.loops.lf, loop_tgt.lf);
    end
    else
    begin
      r_nxt.loops.ut   = step_loop(r.loops.ut, loop_tgt.ut);
      r_nxt.loops.vp   = step_loop(r.loops.vp, loop_tgt.vp);
      r_nxt.loops.gain = 5'(step_loop({2'h0, r.loops.gain}, {2'h0, loop_tgt.gain}));
    end
    // Holds win over every other change of the boosts
    if (r.ctrl.hf_hold)
    begin
      r_nxt.loops.hf = r.loops.hf; // [RQ1]
    end
    if (r.ctrl.lf_hold)
    begin
      r_nxt.loops.lf = r.loops.lf; // [RQ2]
    end

    // Clock recovery integrates phase error unless held
    if (!r.ctrl.cdr_hold)
    begin
      r_nxt.cdr_ph = r.cdr_ph + {{4{phase_err[3]}}, phase_err}; // [RQ4]
    end

    // Monitor mux; reserved code shows zero
    case (r.ctrl.mon_sel) // [RQ8]
      `RXEQD_MON_GAIN:
      begin
        if (VARIANT == 0)
        begin
          r_nxt.mon = {2'h0, r.loops.gain}; // [RQ6]
        end
        else
        begin
          r_nxt.mon = {2'h0, r.loops.gain[3:0], 1'h0}; // [RQ7]
        end
      end
      `RXEQD_MON_UT: r_nxt.mon = r.loops.ut;
      `RXEQD_MON_VP: r_nxt.mon = r.loops.vp;
      default:       r_nxt.mon = 7'h00;
    endcase

    // Eye-scan state machine
    case (r.es)
      ES_WAIT:
      begin
        if (r.ctrl.es_trig)
        begin
          r_nxt.es = ES_ARMED; // [RQ11]
        end
      end
      ES_ARMED:
      begin
        if (r.ctrl.es_trig)
        begin
          r_nxt.es     = ES_COUNT; // [RQ11]
          r_nxt.es_cnt = 8'h00;
        end
      end
      ES_COUNT:
      begin
        r_nxt.es_cnt = r.es_cnt + 8'h01;
        if (r.es_cnt == COUNT_LEN - 8'h01)
        begin
          r_nxt.es = ES_WAIT;
        end
      end
      default: r_nxt.es = ES_WAIT;
    endcase
    // Reset held and one cycle after its release: parked in ES_WAIT
    if (r.ctrl.es_rst || r.es_rst_q)
    begin
      r_nxt.es     = ES_WAIT; // [RQ9]
      r_nxt.es_cnt = 8'h00;
    end
    // Unmasked error in armed or count state gives one pulse
    r_nxt.es_err = er_ev && !r.ctrl.es_mask
                   && (r.es == ES_ARMED || r.es == ES_COUNT); // [RQ10]

    // Alignment: comma aligns, misalign loses it; comma wins a tie
    r_nxt.comma_det = cm_ev; // [RQ13]
    if (cm_ev)
    begin
      r_nxt.aligned = 1'h1; // [RQ12]
    end
    else if (ma_ev)
    begin
      r_nxt.aligned = 1'h0; // [RQ12]
    end
    // Comma reaches the parallel side a fixed latency later
    r_nxt.pipe = {r.pipe[`RXEQD_COMMA_LAT-2:0], r.comma_det}; // [RQ13]

    // Sticky interrupts; a new event beats a clear
    ev                   = '0;
    ev[`RXEQD_IRQ_ESERR] = r_nxt.es_err;
    ev[`RXEQD_IRQ_COMMA] = cm_ev;
    ev[`RXEQD_IRQ_ALOST] = ma_ev && !cm_ev && r.aligned;
    r_nxt.istat          = (r.istat & ~clr) | ev;

    // Read data captured in the setup cycle
    if (psel && !penable)
    begin
      r_nxt.slverr = 1'h0;
      case (paddr)
        `RXEQD_CTRL_OFS:  r_nxt.prdata = {21'h000000, r.ctrl};
        `RXEQD_STAT_OFS:  r_nxt.prdata = {8'h00, r.cdr_ph, 6'h00, r.es, r.aligned, r.mon};
        `RXEQD_ISTAT_OFS: r_nxt.prdata = {29'h00000000, r.istat};
        `RXEQD_IEN_OFS:   r_nxt.prdata = {29'h00000000, r.ien};
        `RXEQD_ICLR_OFS:  r_nxt.prdata = 32'h00000000;
        default:
        begin
          r_nxt.prdata = 32'h00000000;
          r_nxt.slverr = 1'h1;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r      <= '0;
      r.es   <= ES_WAIT;
      r.ctrl <= `RXEQD_CTRL_RST;
      r.loops <= {`RXEQD_BOOST_INIT, `RXEQD_BOOST_INIT, `RXEQD_BOOST_INIT,
                  `RXEQD_BOOST_INIT, `RXEQD_GAIN_INIT};
    end
    else
    begin
      r <= r_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign pready       = psel && penable;
  assign prdata       = r.prdata;
  assign pslverr      = r.slverr && psel && penable;
  assign eq_path_lpm  = r.ctrl.lpm_sel; // [RQ3]
  assign loop_val     = r.loops;
  assign cdr_phase    = r.cdr_ph;
  assign monitor_out  = r.mon;
  assign es_error     = r.es_err;
  assign byte_aligned = r.aligned;
  assign comma_det    = r.comma_det;
  assign comma_at_par = r.pipe[`RXEQD_COMMA_LAT-1];
  assign irq          = |(r.istat & r.ien);

  // ==========================================================
  // Checks
  localparam int LAT = `RXEQD_COMMA_LAT;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence es_pulse_s;
    es_error ##1 !es_error;
  endsequence

  hf_hold_a: assert property (r.ctrl.hf_hold |=> $stable(loop_val.hf)) // [RQ1]
    else $error("hf boost moved under hold");
  lf_adapt_a: assert property (!r.ctrl.lf_hold && r.ctrl.lpm_sel && !r.ctrl.adapt_rst
      && !r.adapt_rst_q && loop_val.lf != loop_tgt.lf |=> !$stable(loop_val.lf)) // [RQ2]
    else $error("lf boost did not adapt");
  path_sel_a: assert property (!r.ctrl.lpm_sel && !r.adapt_rst_q
      |=> $stable(loop_val.hf) && $stable(loop_val.lf)) // [RQ3]
    else $error("boost moved on feedback path");
  cdr_hold_a: assert property (r.ctrl.cdr_hold [*2] |-> $stable(cdr_phase)) // [RQ4]
    else $error("recovery loop moved under hold");
  mon_gain_a: assert property (VARIANT == 0 && r.ctrl.mon_sel == `RXEQD_MON_GAIN
      |=> monitor_out == {2'h0, $past(loop_val.gain)}) // [RQ6]
    else $error("gain not on monitor 4:0");
  mon_gain4_a: assert property (VARIANT == 1 && r.ctrl.mon_sel == `RXEQD_MON_GAIN
      |=> monitor_out[4:1] == $past(loop_val.gain[3:0])) // [RQ7]
    else $error("gain not on monitor 4:1");
  mon_sel_a: assert property (r.ctrl.mon_sel == `RXEQD_MON_UT
      |=> monitor_out == $past(loop_val.ut)) // [RQ8]
    else $error("threshold loop not on monitor");
  es_error_a: assert property (es_error |-> es_pulse_s
      and $past(r.es) inside {ES_ARMED, ES_COUNT}) // [RQ10]
    else $error("bad eye-scan error pulse");
  es_trig_a: assert property (r.es == ES_ARMED && r.ctrl.es_trig && !r.ctrl.es_rst
      && !r.es_rst_q |=> r.es == ES_COUNT) // [RQ11]
    else $error("trigger did not start count");
  align_a: assert property ($rose(r.f_ma) && !$rose(r.f_cm) |-> !byte_aligned) // [RQ12]
    else $error("alignment not lost");
  comma_a: assert property (comma_det |-> ##LAT comma_at_par) // [RQ13]
    else $error("comma missing on parallel side");
endmodule : rxeqd_debug_ports
`default_nettype wire

// *** inc/rxeqd_consts.svh ***
// Purpose: Constants of the receive lane equalizer debug block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
`ifndef RXEQD_CONSTS_SVH
`define RXEQD_CONSTS_SVH
// ==========================================================
// Register map
`define RXEQD_ADDR_W      12
`define RXEQD_CTRL_OFS    12'h000
`define RXEQD_STAT_OFS    12'h004
`define RXEQD_ISTAT_OFS   12'h008
`define RXEQD_IEN_OFS     12'h00C
`define RXEQD_ICLR_OFS    12'h010
// ==========================================================
// Fields and reset values
`define RXEQD_CTRL_W      11
`define RXEQD_CTRL_RST    11'h000
`define RXEQD_IRQ_W       3
`define RXEQD_IRQ_ESERR   0
`define RXEQD_IRQ_COMMA   1
`define RXEQD_IRQ_ALOST   2
`define RXEQD_BOOST_INIT  7'h40
`define RXEQD_GAIN_INIT   5'h10
// ==========================================================
// Monitor select codes
`define RXEQD_MON_RSVD    2'h0
`define RXEQD_MON_GAIN    2'h1
`define RXEQD_MON_UT      2'h2
`define RXEQD_MON_VP      2'h3
// ==========================================================
// Timing counts in clock cycles
`define RXEQD_COMMA_LAT   4
`define RXEQD_COUNT_LEN   8'h40
`endif

// *** inc/rxeqd_pkg.sv ***
// Purpose: Types of the receive lane equalizer debug block
// Assumes: Constants header on the include path
// Notes:   Control struct order matches the control register bits
`include "rxeqd_consts.svh"
package rxeqd_pkg;
  // Control register, bit 10 down to bit 0
  typedef struct packed {
    logic [1:0] mon_sel;   // Monitor loop select
    logic       es_mask;   // Mask eye-scan errors
    logic       es_trig;   // Trigger, self clearing
    logic       es_rst;    // Eye-scan reset
    logic       adapt_rst; // Adaptation reset
    logic       cdr_ovrd;  // Reserved, keep zero
    logic       cdr_hold;  // Freeze clock recovery
    logic       lpm_sel;   // 1 linear path, 0 feedback path
    logic       lf_hold;   // Freeze low-frequency boost
    logic       hf_hold;   // Freeze high-frequency boost
  } rxeqd_ctrl_t;
  // Adaptation loop values
  typedef struct packed {
    logic [6:0] hf;
    logic [6:0] lf;
    logic [6:0] ut;
    logic [6:0] vp;
    logic [4:0] gain;
  } rxeqd_loops_t;
  // Eye-scan states
  typedef enum logic [1:0] {ES_WAIT, ES_ARMED, ES_COUNT} rxeqd_es_t;
  // Whole block state
  typedef struct packed {
    rxeqd_ctrl_t                  ctrl;
    logic                         adapt_rst_q;
    logic                         es_rst_q;
    rxeqd_loops_t                 loops;
    logic [7:0]                   cdr_ph;
    rxeqd_es_t                    es;
    logic [7:0]                   es_cnt;
    logic [2:0]                   s_cm;
    logic [2:0]                   s_er;
    logic [2:0]                   s_ma;
    logic                         f_cm;
    logic                         f_er;
    logic                         f_ma;
    logic [`RXEQD_COMMA_LAT-1:0]  pipe;
    logic                         aligned;
    logic                         comma_det;
    logic                         es_err;
    logic [6:0]                   mon;
    logic [`RXEQD_IRQ_W-1:0]      istat;
    logic [`RXEQD_IRQ_W-1:0]      ien;
    logic [31:0]                  prdata;
    logic                         slverr;
  } rxeqd_state_t;
endpackage : rxeqd_pkg

// *** tb/rxeqd_fe_model.sv ***
// Purpose: Front end stand-in that raises raw lane flags
// Assumes: Raw flags pass a three-flop filter in the block
// Notes:   Each pulse lasts three cycles, then a low gap
`timescale 1ns/1ps
`default_nettype none
module rxeqd_fe_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Requests: 0 error, 1 comma, 2 misalign
  input  wire logic [2:0] fire,
  // Raw flags and phase noise
  output logic            err_raw,
  output logic            comma_raw,
  output logic            misalign_raw,
  output logic [3:0]      phase_err
);
  logic [2:0]  sh_e, sh_c, sh_m; // Pulse stretchers
  logic [15:0] ph_r;             // Phase noise source
  // ==========================================================
  // Stretch requests so the filter never drops them
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sh_e <= 3'h0;
      sh_c <= 3'h0;
      sh_m <= 3'h0;
      ph_r <= 16'hACE1;
    end
    else
    begin
      sh_e <= fire[0] ? 3'h7 : sh_e >> 1;
      sh_c <= fire[1] ? 3'h7 : sh_c >> 1;
      sh_m <= fire[2] ? 3'h7 : sh_m >> 1;
      ph_r <= {ph_r[14:0], ph_r[15] ^ ph_r[13] ^ ph_r[12] ^ ph_r[10]};
    end
  assign err_raw      = |sh_e;
  assign comma_raw    = |sh_c;
  assign misalign_raw = |sh_m;
  assign phase_err    = ph_r[3:0];
endmodule : rxeqd_fe_model
`default_nettype wire

// *** tb/tb_rxeqd_debug_ports.sv ***
// Purpose: Self-checking bench of the lane debug block
// Assumes: APB slave answers in its own time, both monitor layouts
// Notes:   Loop targets drawn from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
`include "rxeqd_consts.svh"
module tb_rxeqd_debug_ports
  import rxeqd_pkg::*;
;
  localparam rxeqd_loops_t INIT = {{4{`RXEQD_BOOST_INIT}}, `RXEQD_GAIN_INIT};
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd, rnd;
  logic [2:0]   fire;
  logic [3:0]   phase_err;
  logic         comma_raw, err_raw, misalign_raw, eq_path_lpm, es_error;
  logic         byte_aligned, comma_det, comma_at_par, irq;
  logic [7:0]   cdr_phase, ph0;
  logic [6:0]   monitor_out, mon_v1;
  rxeqd_loops_t tgt, loop_val, lv0;
  rxeqd_ctrl_t  cw;
  int           fails, checks_done, n_err, n_cm, cyc, t_cm;
  // ==========================================================
  // Design and front end
  rxeqd_debug_ports #(.VARIANT(0)) uut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loop_tgt(tgt), .phase_err(phase_err), .comma_raw(comma_raw),
    .err_raw(err_raw), .misalign_raw(misalign_raw), .eq_path_lpm(eq_path_lpm),
    .loop_val(loop_val), .cdr_phase(cdr_phase), .monitor_out(monitor_out),
    .es_error(es_error), .byte_aligned(byte_aligned), .comma_det(comma_det),
    .comma_at_par(comma_at_par), .irq(irq));
  rxeqd_fe_model fe (.pclk(pclk), .presetn(presetn), .fire(fire),
    .err_raw(err_raw), .comma_raw(comma_raw), .misalign_raw(misalign_raw),
    .phase_err(phase_err));
  // Second variant shares every input; only its monitor is watched
  rxeqd_debug_ports #(.VARIANT(1)) uut_v1 (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .loop_tgt(tgt), .phase_err(phase_err), .comma_raw(comma_raw),
    .err_raw(err_raw), .misalign_raw(misalign_raw), .eq_path_lpm(),
    .loop_val(), .cdr_phase(), .monitor_out(mon_v1),
    .es_error(), .byte_aligned(), .comma_det(),
    .comma_at_par(), .irq());
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [6:0] mon_exp(input logic [1:0] s, input rxeqd_loops_t l);
    case (s)
      2'h1: return {2'h0, l.gain};
      2'h2: return l.ut;
      2'h3: return l.vp;
      default: return 7'h00;
    endcase
  endfunction : mon_exp
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, s);
      fails++;
    end
  endtask : chk
  // One APB transfer; holds the request until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wc();
    apb(1'b1, `RXEQD_CTRL_OFS, {21'h0, cw});
  endtask : wc
  // Fire one front-end event, then let the filter settle
  task automatic ev(input int i);
    @(posedge pclk);
    fire <= 3'b001 << i;
    @(posedge pclk);
    fire <= 3'b000;
    repeat (14) @(posedge pclk);
    @(negedge pclk);
  endtask : ev
  // New targets at a rising edge; every field drawn from the shift register
  task automatic newtgt();
    @(posedge pclk);
    rnd = lfsr(rnd);
    tgt <= {rnd[0], rnd};
    repeat (200) @(posedge pclk);
    @(negedge pclk);
  endtask : newtgt
  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // ==========================================================
  // Clock, watchdog and pulse monitors (sampled off the edge)
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial
  begin
    #(5 * 20000);
    fails++;
    stop_test();
  end
  always @(negedge pclk)
  begin
    cyc++;
    if (es_error === 1'b1)
      n_err++;
    if (comma_det === 1'b1)
    begin
      n_cm++;
      t_cm = cyc;
    end
    if (comma_at_par === 1'b1)
      chk("par_delay", 32'h4, 32'(cyc - t_cm));
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, fire, presetn} = '0;
    {fails, checks_done, n_err, n_cm, cyc, t_cm} = '0;
    cw  = '0;
    tgt = INIT;
    rnd = 32'h67EA;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("loops_rst", 32'(INIT), 32'(loop_val));
    apb(1'b0, `RXEQD_CTRL_OFS, 32'h0);
    chk("ctrl_rst", 32'h0, rd);
    newtgt();
    chk("ut", 32'(tgt.ut), 32'(loop_val.ut));
    chk("hf_fb", 32'h40, 32'(loop_val.hf));
    // Reserved select code shows nothing
    chk("mon_rsvd", 32'h0, 32'(monitor_out));
    for (int s = 1; s < 4; s++)
    begin
      cw.mon_sel = 2'(s);
      wc();
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("mon", 32'(mon_exp(2'(s), tgt)), 32'(monitor_out));
      // Four-bit gain sits one bit up in the second variant
      if (s == 1)
        chk("mon_v1", 32'(tgt.gain[3:0]), 32'(mon_v1[4:1]));
    end
    cw.lpm_sel = 1'b1;
    cw.hf_hold = 1'b1;
    wc();
    newtgt();
    chk("lpm", 32'h1, 32'(eq_path_lpm));
    chk("hf_held", 32'h40, 32'(loop_val.hf));
    chk("lf_adapt", 32'(tgt.lf), 32'(loop_val.lf));
    cw.hf_hold = 1'b0;
    cw.lf_hold = 1'b1;
    wc();
    lv0 = tgt;
    newtgt();
    chk("hf_adapt", 32'(tgt.hf), 32'(loop_val.hf));
    chk("lf_held", 32'(lv0.lf), 32'(loop_val.lf));
    cw.cdr_hold = 1'b1;
    wc();
    @(negedge pclk);
    ph0 = cdr_phase;
    repeat (20) @(posedge pclk);
    @(negedge pclk);
    chk("cdr_held", 32'(ph0), 32'(cdr_phase));
    cw.cdr_hold = 1'b0;
    cw.adapt_rst = 1'b1;
    wc();
    // Loops wait while the reset is held, even for a new target
    lv0 = tgt;
    newtgt();
    chk("adapt_frozen", 32'(lv0.hf), 32'(loop_val.hf));
    cw.adapt_rst = 1'b0;
    cw.es_rst = 1'b1;
    wc();
    // Reload lands one cycle after the release is seen
    @(negedge pclk);
    @(negedge pclk);
    chk("hf_reload", 32'(`RXEQD_BOOST_INIT), 32'(loop_val.hf));
    chk("ut_reload", 32'(`RXEQD_BOOST_INIT), 32'(loop_val.ut));
    cw.es_rst = 1'b0;
    wc();
    ev(0);
    chk("err_wait", 32'h0, 32'(n_err));
    for (int k = 1; k < 3; k++)
    begin
      cw.es_trig = 1'b1;
      wc();
      cw.es_trig = 1'b0;
      apb(1'b0, `RXEQD_STAT_OFS, 32'h0);
      chk("es_state", 32'(k), 32'(rd[9:8]));
      ev(0);
      chk("err_pulse", 32'(k), 32'(n_err));
    end
    repeat (80) @(posedge pclk);
    // Count window over, back to waiting
    apb(1'b0, `RXEQD_STAT_OFS, 32'h0);
    chk("es_done", 32'h0, 32'(rd[9:8]));
    // Mask tested while armed, where an error would otherwise pulse
    cw.es_mask = 1'b1;
    cw.es_trig = 1'b1;
    wc();
    cw.es_trig = 1'b0;
    ev(0);
    chk("err_mask", 32'h2, 32'(n_err));
    ev(1);
    chk("comma", 32'h1, 32'(n_cm));
    chk("aligned", 32'h1, 32'(byte_aligned));
    apb(1'b0, `RXEQD_ISTAT_OFS, 32'h0);
    chk("istat", 32'h3, rd);
    apb(1'b1, `RXEQD_IEN_OFS, 32'h2);
    @(negedge pclk);
    chk("irq_on", 32'h1, 32'(irq));
    apb(1'b1, `RXEQD_ICLR_OFS, 32'h2);
    @(negedge pclk);
    chk("irq_clr", 32'h0, 32'(irq));
    apb(1'b1, `RXEQD_IEN_OFS, 32'h4);
    ev(2);
    chk("unaligned", 32'h0, 32'(byte_aligned));
    chk("irq_lost", 32'h1, 32'(irq));
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h1, 32'(er));
    // Mid-run reset clears flags, loops and control
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk("irq_rst", 32'h0, 32'(irq));
    chk("loops_rst2", 32'(INIT), 32'(loop_val));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("aligned_rst", 32'h0, 32'(byte_aligned));
    apb(1'b0, `RXEQD_CTRL_OFS, 32'h0);
    chk("ctrl_rst2", 32'h0, rd);
    stop_test();
  end
endmodule : tb_rxeqd_debug_ports
`default_nettype wire
